// [gpde_defs.svh]
// Register offsets, field positions and reset values for the dual GPIO port
`ifndef GPDE_DEFS_SVH
`define GPDE_DEFS_SVH
`define GPDE_ADDR_W 3
`define GPDE_OFF_WPIN 3'h0
`define GPDE_OFF_WLAT 3'h1
`define GPDE_OFF_WDIR 3'h2
`define GPDE_OFF_NPIN 3'h3
`define GPDE_OFF_NLAT 3'h4
`define GPDE_OFF_NCTL 3'h5
`define GPDE_OFF_ANSEL 3'h6
`define GPDE_WDIR_RST 8'hFF
`define GPDE_NDIR_RST 3'h7
`define GPDE_ANSEL_RST 3'h7
`define GPDE_LAT_RST 8'h00
`define GPDE_NLAT_RST 3'h0
`define GPDE_MODE_BIT 4
`define GPDE_UNMAPPED 32'h00000000
`endif

// [gpde_pkg.sv]
// Types shared by the dual GPIO port
package gpde_pkg;
  typedef struct packed {
    logic [7:0] wideOut;
    logic [7:0] wideOe;
    logic [2:0] narrowOut;
    logic [2:0] narrowOe;
  } gpde_pins_t;
  typedef enum logic [2:0] {
    GPDE_IDLE = 3'b001,
    GPDE_ACC = 3'b010,
    GPDE_DONE = 3'b100
  } gpde_state_t;
endpackage

// [gpde_regfile.sv]
// Small register store for the two port direction and latch words
`timescale 1ns/100ps
`include "gpde_defs.svh"
module gpde_regfile #(
  parameter int WIDE_W = 8,
  parameter int NARROW_W = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Write side
  input wire logic wrEn,
  input wire logic [`GPDE_ADDR_W-1:0] wrAddr,
  input wire logic [31:0] wrData,
  // Stored values
  output logic [WIDE_W-1:0] wideLat,
  output logic [WIDE_W-1:0] wideDir,
  output logic [NARROW_W-1:0] narrowLat,
  output logic [NARROW_W-1:0] narrowDir,
  output logic modeSel,
  output logic [NARROW_W-1:0] analogSel
);
  // Wide latch: written through either the latch or the pin-data offset
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      wideLat <= `GPDE_LAT_RST;
    else if (wrEn && (wrAddr == `GPDE_OFF_WLAT || wrAddr == `GPDE_OFF_WPIN))
      wideLat <= wrData[WIDE_W-1:0];
  // Wide direction comes up all inputs
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      wideDir <= `GPDE_WDIR_RST;
    else if (wrEn && wrAddr == `GPDE_OFF_WDIR)
      wideDir <= wrData[WIDE_W-1:0];
  // Narrow latch
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      narrowLat <= `GPDE_NLAT_RST;
    else if (wrEn && (wrAddr == `GPDE_OFF_NLAT || wrAddr == `GPDE_OFF_NPIN))
      narrowLat <= wrData[NARROW_W-1:0];
  // Narrow control: mode bit and direction bits
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      narrowDir <= `GPDE_NDIR_RST;
      modeSel <= 1'b0;
    end
    else if (wrEn && wrAddr == `GPDE_OFF_NCTL)
    begin
      narrowDir <= wrData[NARROW_W-1:0];
      modeSel <= wrData[`GPDE_MODE_BIT];
    end
  // Analog select comes up all analog
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      analogSel <= `GPDE_ANSEL_RST;
    else if (wrEn && wrAddr == `GPDE_OFF_ANSEL)
      analogSel <= wrData[NARROW_W-1:0];
endmodule

// [gpde_port.sv]
// Dual GPIO port: eight-bit wide port and three-bit narrow port
//
// What this block does
// - Wide pin drives latch when direction bit 0, except in slave-port mode
// - Narrow pins likewise: 1 input, 0 drive latch
// - Wide direction resets to all ones
// - Wide latch register reads back the latch
// - Narrow latch register reads back the latch
// - Mode bit makes wide port a slave data port
// - Slave data bit n rides wide pin n
// - Analog-selected narrow pins read as zero
// - Narrow pins come up analog after reset
// - Control bit 4 selects slave-port mode
// - Control bit 3 reads zero; bits 2-0 direction
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`include "gpde_defs.svh"
module gpde_port #(
  parameter int WIDE_W = 8,
  parameter int NARROW_W = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [`GPDE_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // Pins
  input wire logic [WIDE_W-1:0] widePinIn,
  input wire logic [NARROW_W-1:0] narrowPinIn,
  output gpde_pkg::gpde_pins_t pins,
  // Pin buffer threshold: high selects TTL levels on the wide port
  output logic wideTtlSel,
  // Slave-port mode: pins hand their data path to the slave port logic
  output logic slavePortEn,
  output logic [WIDE_W-1:0] slaveDataIn
);
  gpde_pkg::gpde_state_t state_q;
  gpde_pkg::gpde_state_t state_d;
  logic [WIDE_W-1:0] wideLat;
  logic [WIDE_W-1:0] wideDir;
  logic [NARROW_W-1:0] narrowLat;
  logic [NARROW_W-1:0] narrowDir;
  logic [NARROW_W-1:0] analogSel;
  logic modeSel;
  logic wrEn;
  logic [31:0] rdMux;
  logic [WIDE_W-1:0] wideSync_q;
  logic [NARROW_W-1:0] narrowSync_q;

  // Zero-extend a narrow field into a bus word
  function automatic logic [31:0] ext8(input logic [7:0] v);
    ext8 = {24'h000000, v};
  endfunction

  // Narrow pin read with analog pins forced low
  function automatic logic [7:0] narrowRead(
    input logic [NARROW_W-1:0] pinv,
    input logic [NARROW_W-1:0] ana
  );
    narrowRead = 8'h00;
    narrowRead[NARROW_W-1:0] = pinv & ~ana;
  endfunction

  gpde_regfile #(
    .WIDE_W(WIDE_W),
    .NARROW_W(NARROW_W)
  ) uRegs (
    .mclk(mclk),
    .rst(rst),
    .wrEn(wrEn),
    .wrAddr(avsAddress),
    .wrData(avsWritedata),
    .wideLat(wideLat),
    .wideDir(wideDir),
    .narrowLat(narrowLat),
    .narrowDir(narrowDir),
    .modeSel(modeSel),
    .analogSel(analogSel)
  );

  // Bus handshake: two wait cycles, then the answer edge
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      gpde_pkg::GPDE_IDLE:
        if (avsRead || avsWrite)
          state_d = gpde_pkg::GPDE_ACC;
      gpde_pkg::GPDE_ACC:
        state_d = gpde_pkg::GPDE_DONE;
      gpde_pkg::GPDE_DONE:
        state_d = gpde_pkg::GPDE_IDLE;
      default:
        state_d = gpde_pkg::GPDE_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      state_q <= gpde_pkg::GPDE_IDLE;
    else
      state_q <= state_d;

  // Waitrequest falls for exactly the answer cycle
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      avsWaitrequest <= 1'b1;
    else
      avsWaitrequest <= !(state_d == gpde_pkg::GPDE_DONE);

  // Write takes effect at the edge where waitrequest is sampled low;
  // byte lane 0 must be enabled since all fields sit there
  assign wrEn = (state_q == gpde_pkg::GPDE_DONE) && avsWrite &&
                avsByteenable[0];

  // Pin samples registered once; inputs are already synchronous
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      wideSync_q <= '0;
      narrowSync_q <= '0;
    end
    else
    begin
      wideSync_q <= widePinIn;
      narrowSync_q <= narrowPinIn;
    end

  // Read data selection; unmapped offsets answer zero
  always_comb
  begin
    case (avsAddress)
      `GPDE_OFF_WPIN: rdMux = ext8(wideSync_q);
      `GPDE_OFF_WLAT: rdMux = ext8(wideLat);
      `GPDE_OFF_WDIR: rdMux = ext8(wideDir);
      `GPDE_OFF_NPIN: rdMux = ext8(narrowRead(narrowSync_q, analogSel));
      `GPDE_OFF_NLAT: rdMux = ext8({5'h00, narrowLat});
      // Flag bits 7..5 belong to the slave-port job and read zero here
      `GPDE_OFF_NCTL: rdMux = ext8({3'h0, modeSel, 1'b0, narrowDir});
      `GPDE_OFF_ANSEL: rdMux = ext8({5'h00, analogSel});
      default: rdMux = `GPDE_UNMAPPED;
    endcase
  end

  // Read data registered so it stands at the answer edge
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      avsReaddata <= `GPDE_UNMAPPED;
    else if (state_d == gpde_pkg::GPDE_DONE && avsRead)
      avsReaddata <= rdMux;

  // Wide pin drivers; slave mode leaves the data path to the slave port,
  // which is not built here, so the pins are released to input
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      pins.wideOut <= `GPDE_LAT_RST;
      pins.wideOe <= '0;
    end
    else
    begin
      pins.wideOut <= wideLat;
      pins.wideOe <= modeSel ? '0 : ~wideDir;
    end

  // Narrow pin drivers: direction still rules even when analog
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      pins.narrowOut <= `GPDE_NLAT_RST;
      pins.narrowOe <= '0;
    end
    else
    begin
      pins.narrowOut <= narrowLat;
      pins.narrowOe <= ~narrowDir;
    end

  // Slave-port mode outputs: TTL thresholds and per-bit data
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      wideTtlSel <= 1'b0;
      slavePortEn <= 1'b0;
      slaveDataIn <= '0;
    end
    else
    begin
      wideTtlSel <= modeSel;
      slavePortEn <= modeSel;
      slaveDataIn <= modeSel ? widePinIn : '0;
    end

  // Assertions
  property p_wdir_reset;
    @(posedge mclk) $fell(rst) |-> uRegs.wideDir == `GPDE_WDIR_RST;
  endproperty
  a_wdir_reset: assert property (p_wdir_reset)
    else $error("wide direction not all ones after reset");

  property p_wide_drive;
    @(posedge mclk) disable iff (rst)
    ##1 pins.wideOe == ($past(modeSel) ? 8'h00 : ~$past(wideDir));
  endproperty
  a_wide_drive: assert property (p_wide_drive)
    else $error("wide output enable mismatches direction");

  property p_narrow_drive;
    @(posedge mclk) disable iff (rst)
    ##1 pins.narrowOe == ~$past(narrowDir) &&
        pins.narrowOut == $past(narrowLat);
  endproperty
  a_narrow_drive: assert property (p_narrow_drive)
    else $error("narrow pins mismatch latch or direction");

  property p_latch_read;
    @(posedge mclk) disable iff (rst)
    (state_d == gpde_pkg::GPDE_DONE && avsRead &&
     avsAddress == `GPDE_OFF_WLAT) |=> avsReaddata == ext8(wideLat);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch read not latch value");

  property p_nlatch_read;
    @(posedge mclk) disable iff (rst)
    (state_d == gpde_pkg::GPDE_DONE && avsRead &&
     avsAddress == `GPDE_OFF_NLAT) |=> avsReaddata[2:0] == narrowLat;
  endproperty
  a_nlatch_read: assert property (p_nlatch_read)
    else $error("narrow latch read wrong");

  property p_ttl;
    @(posedge mclk) disable iff (rst)
    modeSel |=> wideTtlSel && pins.wideOe == 8'h00;
  endproperty
  a_ttl: assert property (p_ttl)
    else $error("slave mode not applied");

  property p_slave_bits;
    @(posedge mclk) disable iff (rst)
    modeSel |=> slaveDataIn == $past(widePinIn);
  endproperty
  a_slave_bits: assert property (p_slave_bits)
    else $error("slave data bits misplaced");

  property p_analog_zero;
    @(posedge mclk) disable iff (rst)
    (state_d == gpde_pkg::GPDE_DONE && avsRead &&
     avsAddress == `GPDE_OFF_NPIN) |=> (avsReaddata[2:0] & analogSel) == 3'h0;
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("analog pin read nonzero");

  property p_analog_reset;
    @(posedge mclk) $fell(rst) |-> analogSel == `GPDE_ANSEL_RST;
  endproperty
  a_analog_reset: assert property (p_analog_reset)
    else $error("narrow pins not analog after reset");

  property p_ctl_read;
    @(posedge mclk) disable iff (rst)
    (state_d == gpde_pkg::GPDE_DONE && avsRead &&
     avsAddress == `GPDE_OFF_NCTL) |=>
    avsReaddata[3] == 1'b0 && avsReaddata[4] == modeSel;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control register read wrong");

  property p_pin_write;
    @(posedge mclk) disable iff (rst)
    (wrEn && avsAddress == `GPDE_OFF_WPIN) |=>
    wideLat == $past(avsWritedata[WIDE_W-1:0]);
  endproperty
  a_pin_write: assert property (p_pin_write)
    else $error("pin data write did not set latch");

  // Narrow pin-data offset is a second way into the narrow latch
  property p_narrow_write;
    @(posedge mclk) disable iff (rst)
    (wrEn && avsAddress == `GPDE_OFF_NPIN) |=>
    narrowLat == $past(avsWritedata[NARROW_W-1:0]);
  endproperty
  a_narrow_write: assert property (p_narrow_write)
    else $error("narrow pin data write did not set latch");

  // Pin-data read returns the registered pin sample, not the latch
  property p_wpin_read;
    @(posedge mclk) disable iff (rst)
    (state_d == gpde_pkg::GPDE_DONE && avsRead &&
     avsAddress == `GPDE_OFF_WPIN) |=>
    avsReaddata == ext8($past(wideSync_q));
  endproperty
  a_wpin_read: assert property (p_wpin_read)
    else $error("pin data read not the pin levels");

  // Digital narrow pins pass their level; only analog ones are masked
  property p_analog_pass;
    @(posedge mclk) disable iff (rst)
    (state_d == gpde_pkg::GPDE_DONE && avsRead &&
     avsAddress == `GPDE_OFF_NPIN) |=>
    avsReaddata[NARROW_W-1:0] == ($past(narrowSync_q) & ~analogSel);
  endproperty
  a_analog_pass: assert property (p_analog_pass)
    else $error("narrow pin read wrong");

  // Direction bits read back in the low field of the control word
  property p_ctl_dir;
    @(posedge mclk) disable iff (rst)
    (state_d == gpde_pkg::GPDE_DONE && avsRead &&
     avsAddress == `GPDE_OFF_NCTL) |=>
    avsReaddata[NARROW_W-1:0] == narrowDir;
  endproperty
  a_ctl_dir: assert property (p_ctl_dir)
    else $error("narrow direction read wrong");

  // Drive value follows the latch one edge later
  property p_wide_out;
    @(posedge mclk) disable iff (rst)
    ##1 pins.wideOut == $past(wideLat);
  endproperty
  a_wide_out: assert property (p_wide_out)
    else $error("wide pin drive value is not the latch");

  // Leaving slave mode hands the pins back and clears the slave outputs
  property p_slave_off;
    @(posedge mclk) disable iff (rst)
    !modeSel |=> !wideTtlSel && !slavePortEn && slaveDataIn == '0;
  endproperty
  a_slave_off: assert property (p_slave_off)
    else $error("slave outputs active outside slave mode");

  // No pin may be driven at the first edge after reset
  property p_oe_reset;
    @(posedge mclk) $fell(rst) |->
    pins.wideOe == 8'h00 && pins.narrowOe == 3'h0;
  endproperty
  a_oe_reset: assert property (p_oe_reset)
    else $error("pin driven right after reset");

  // Control comes up in port mode with all narrow pins as inputs
  property p_ctl_reset;
    @(posedge mclk) $fell(rst) |->
    narrowDir == `GPDE_NDIR_RST && !modeSel;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset)
    else $error("control word wrong after reset");
endmodule

// [gpde_pin_model.sv]
// Board-side model of the port pins: drivers meet external levels
`timescale 1ns/100ps
module gpde_pin_model (
  // Drivers from the port
  input wire gpde_pkg::gpde_pins_t pins,
  // Levels the board puts on undriven pins
  input wire logic [7:0] extWide,
  input wire logic [2:0] extNarrow,
  // Resolved pin levels back to the port
  output logic [7:0] widePinIn,
  output logic [2:0] narrowPinIn
);
  // Driven bits show the latch; board levels differ so a leak shows
  assign widePinIn = (pins.wideOut & pins.wideOe)
    | (extWide & ~pins.wideOe);
  assign narrowPinIn = (pins.narrowOut & pins.narrowOe)
    | (extNarrow & ~pins.narrowOe);
endmodule

// [dual_port_gpio_d_e_bench.sv]
// Self-checking bench for the dual GPIO port
`timescale 1ns/100ps
`include "gpde_defs.svh"
module dual_port_gpio_d_e_bench;
  typedef struct packed {
    logic [2:0] wa;
    logic [7:0] wd;
    logic [2:0] ra;
    logic [7:0] ex;
  } gpde_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] avsAddress = 3'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h00000000;
  logic [3:0] avsByteenable = 4'hF;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [7:0] widePinIn;
  logic [2:0] narrowPinIn;
  gpde_pkg::gpde_pins_t pins;
  logic wideTtlSel;
  logic slavePortEn;
  logic [7:0] slaveDataIn;
  logic [7:0] extWide = 8'h5A;
  logic [2:0] extNarrow = 3'h2;
  logic [31:0] q;
  int nFail = 0;
  int checksDone = 0;
  gpde_row_t rows [8] = '{
    '{`GPDE_OFF_WLAT, 8'h5A, `GPDE_OFF_WLAT, 8'h5A},
    '{`GPDE_OFF_WDIR, 8'h00, `GPDE_OFF_WDIR, 8'h00},
    '{`GPDE_OFF_NLAT, 8'h06, `GPDE_OFF_NLAT, 8'h06},
    '{`GPDE_OFF_NCTL, 8'hFF, `GPDE_OFF_NCTL, 8'h17},
    '{`GPDE_OFF_NCTL, 8'h0F, `GPDE_OFF_NCTL, 8'h07},
    '{`GPDE_OFF_WPIN, 8'h3C, `GPDE_OFF_WLAT, 8'h3C},
    '{`GPDE_OFF_NPIN, 8'h03, `GPDE_OFF_NLAT, 8'h03},
    '{3'h7, 8'hFF, 3'h7, 8'h00}
  };
  // 20 MHz clock
  always #25 mclk = ~mclk;
  gpde_port i_dut (.mclk(mclk), .rst(rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .widePinIn(widePinIn),
    .narrowPinIn(narrowPinIn), .pins(pins), .wideTtlSel(wideTtlSel),
    .slavePortEn(slavePortEn), .slaveDataIn(slaveDataIn));
  gpde_pin_model i_pins (.pins(pins), .extWide(extWide),
    .extNarrow(extNarrow), .widePinIn(widePinIn),
    .narrowPinIn(narrowPinIn));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      nFail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
    input logic [3:0] be);
    @(posedge mclk);
    avsAddress <= a;
    avsWritedata <= {24'h000000, d};
    avsByteenable <= be;
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge mclk); while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [2:0] a);
    bus(1'b0, a, 8'h00, 4'hF);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog: the run needs about 155 cycles
  initial
  begin
    #100000;
    nFail++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    chk(pins.wideOe, 8'h00);
    rd(`GPDE_OFF_WDIR);
    chk(q, 32'h000000FF);
    rd(`GPDE_OFF_NCTL);
    chk(q, 32'h00000007);
    rd(`GPDE_OFF_ANSEL);
    chk(q, 32'h00000007);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      chk(q, {24'h000000, rows[i].ex});
    end
    $display("register rows done");
    // Mixed directions: driven bits read latch, others read the board
    wr(`GPDE_OFF_WLAT, 8'hA5);
    wr(`GPDE_OFF_WDIR, 8'h0F);
    rd(`GPDE_OFF_WPIN);
    chk(q, 32'h000000AA);
    chk(pins.wideOe, 8'hF0);
    wr(`GPDE_OFF_ANSEL, 8'h00);
    wr(`GPDE_OFF_NCTL, 8'h02);
    wr(`GPDE_OFF_NLAT, 8'h05);
    rd(`GPDE_OFF_NPIN);
    chk(q, 32'h00000007);
    chk(pins.narrowOe, 3'h5);
    // Inputs first, then analog, so no driver fights the analog source
    wr(`GPDE_OFF_NCTL, 8'h07);
    wr(`GPDE_OFF_ANSEL, 8'h07);
    rd(`GPDE_OFF_NPIN);
    chk(q, 32'h00000000);
    $display("direction test done");
    // Board word is not bit-symmetric, so a swapped lane would show
    extWide <= 8'hC6;
    wr(`GPDE_OFF_NCTL, 8'h17);
    rd(`GPDE_OFF_NCTL);
    chk(q, 32'h00000017);
    chk({wideTtlSel, slavePortEn}, 2'h3);
    chk(slaveDataIn, 8'hC6);
    chk(pins.wideOe, 8'h00);
    wr(`GPDE_OFF_NCTL, 8'h07);
    rd(`GPDE_OFF_NCTL);
    chk({wideTtlSel, slavePortEn, slaveDataIn}, 10'h000);
    $display("slave mode test done");
    // Lane 0 off: write must be dropped
    bus(1'b1, `GPDE_OFF_WLAT, 8'h11, 4'hE);
    rd(`GPDE_OFF_WLAT);
    chk(q, 32'h000000A5);
    // Second reset in mid-run
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(pins.wideOe, 8'h00);
    rst <= 1'b0;
    rd(`GPDE_OFF_WDIR);
    chk(q, 32'h000000FF);
    $display("edge case test done");
    report_and_stop();
  end
endmodule
